// ### rtl/crb_pkg.sv
// Package for the display timing register bank
package crb_pkg;
  localparam int CRB_REG_COUNT = 24;
  localparam logic [4:0] CRB_IDX_HTOTAL = 5'h00;
  localparam logic [4:0] CRB_IDX_HDISP = 5'h01;
  localparam logic [4:0] CRB_IDX_HSYNC = 5'h02;
  localparam logic [4:0] CRB_IDX_SYNCW = 5'h03;
  localparam logic [4:0] CRB_IDX_VTOTAL = 5'h04;
  localparam logic [4:0] CRB_IDX_VADJ = 5'h05;
  localparam logic [4:0] CRB_IDX_VDISP = 5'h06;
  localparam logic [4:0] CRB_IDX_VSYNC = 5'h07;
  localparam logic [4:0] CRB_IDX_MODE = 5'h08;
  localparam logic [4:0] CRB_IDX_LINES = 5'h09;
  localparam logic [4:0] CRB_IDX_CURS = 5'h0A;
  localparam logic [4:0] CRB_IDX_CURE = 5'h0B;
  localparam logic [4:0] CRB_IDX_ORG_H = 5'h0C;
  localparam logic [4:0] CRB_IDX_ORG_L = 5'h0D;
  localparam logic [4:0] CRB_IDX_CUR_H = 5'h0E;
  localparam logic [4:0] CRB_IDX_CUR_L = 5'h0F;
  localparam logic [4:0] CRB_IDX_PEN_H = 5'h10;
  localparam logic [4:0] CRB_IDX_PEN_L = 5'h11;
  localparam logic [4:0] CRB_IDX_SPLIT = 5'h12;
  localparam logic [4:0] CRB_IDX_LAST = 5'h17;
  localparam logic [7:0] CRB_RESET_VALUE = 8'h00;
  localparam logic [3:0] CRB_VSYNC_ZERO_LINES = 4'h0;
  localparam logic [4:0] CRB_VSYNC_MAX_LINES = 5'h10;
  localparam logic [8:0] CRB_ONE = 9'h001;
  localparam logic [5:0] CRB_TWO = 6'h02;
  localparam int CRB_SKEW_LSB = 4;
  localparam int CRB_CSKEW_LSB = 6;
  localparam int CRB_CMODE_LSB = 5;
  localparam int CRB_TOP_BIT = 7;
  localparam int CRB_LINES_W = 5;

  typedef enum logic [1:0] {
    CRB_RASTER_PLAIN = 2'h0,
    CRB_RASTER_PLAIN_ALT = 2'h1,
    CRB_RASTER_ILACE_SYNC = 2'h2,
    CRB_RASTER_ILACE_VIDEO = 2'h3
  } crb_raster_e;

  typedef enum logic [1:0] {
    CRB_CURSOR_STEADY = 2'h0,
    CRB_CURSOR_HIDDEN = 2'h1,
    CRB_CURSOR_BLINK16 = 2'h2,
    CRB_CURSOR_BLINK32 = 2'h3
  } crb_cursor_e;

  typedef struct packed {
    logic [8:0] h_period;
    logic [7:0] h_displayed;
    logic [8:0] h_sync_start;
    logic [3:0] hsync_width_bits;
    logic [4:0] vsync_lines;
    logic [8:0] v_rows;
    logic [8:0] v_sync_row;
    logic [5:0] row_line_count;
    crb_raster_e raster_mode;
    logic [1:0] visible_skew;
    logic [1:0] cursor_skew;
    crb_cursor_e cursor_mode;
    logic cursor_screen_select;
    logic dual_screen_select;
    logic [15:0] display_origin;
    logic [15:0] cursor_location;
  } crb_timing_s;
endpackage

// ### rtl/crb_timing_regs.sv
// Indexed register bank of the display timing controller
//
// Notes on behaviour
// (RULE_01) Host writes index first, then accesses data
// (RULE_02) Write-only 5-bit index selects registers 0-23
// (RULE_03) Totals and sync positions hold count minus one
// (RULE_04) Row lines minus one, minus two interlace-video
// (RULE_05) Host keeps horizontal total odd when interlaced
// (RULE_06) Low nibble: hsync width in characters
// (RULE_07) High nibble: vsync lines, zero means sixteen
// (RULE_08) Mode bits 1:0 select raster mode
// (RULE_09) Mode bits 5:4 delay display enable
// (RULE_10) Mode bits 7:6 delay cursor display
// (RULE_11) Cursor start bits 6:5 select cursor mode
// (RULE_12) Cursor start bit 7 picks LCD screen
// (RULE_13) Split start bit 7 selects screen count
// (RULE_14) Horizontal period is total plus one
// (RULE_15) Host leaves nonzero retrace in LCD use
// (RULE_16) Suggested total is displayed plus skew
// (RULE_17) Displayed count per line, below total
// (RULE_18) Hsync starts at position plus one
// (RULE_19) Display origin pair is read/write
// (RULE_20) Cursor location pair is read/write
// (RULE_21) Pen capture pair is read-only
// (RULE_22) Index 24-31: no write, reads zero
// (RULE_23) Chip select high: ignored, bus undriven
`timescale 1ns/1ns
`default_nettype none
module crb_timing_regs
  import crb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic chip_select_b,
  input wire logic register_select,
  input wire logic read_not_write,
  input wire logic bus_strobe,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_b,
  input wire logic [15:0] pen_capture,
  output crb_timing_s timing
);
  logic rst_meta_b;
  logic rst_sync_b;
  logic [4:0] register_index;
  logic [7:0] bank [CRB_REG_COUNT];
  logic [7:0] read_data;
  logic [7:0] pen_high;
  logic [7:0] pen_low;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  wire selected = !chip_select_b; // [RULE_23]
  wire index_valid = register_index <= CRB_IDX_LAST; // [RULE_22]
  wire index_write = selected && bus_strobe && !register_select && !read_not_write; // [RULE_01]
  wire data_write = selected && bus_strobe && register_select && !read_not_write && index_valid;
  wire data_read = selected && register_select && read_not_write;
  wire pen_sel = register_index == CRB_IDX_PEN_H || register_index == CRB_IDX_PEN_L; // [RULE_21]
  wire readable = register_index >= CRB_IDX_ORG_H && register_index <= CRB_IDX_PEN_L;
  wire [7:0] next_data_out = (readable && index_valid)
                             ? (pen_sel ? (register_index == CRB_IDX_PEN_H ? pen_high : pen_low)
                                        : bank[register_index])
                             : CRB_RESET_VALUE; // [RULE_22]
  assign pen_high = pen_capture[15:8];
  assign pen_low = pen_capture[7:0];
  assign read_data = next_data_out;

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      register_index <= 5'h00;
    end else if (index_write) begin
      register_index <= data_in[4:0]; // [RULE_02]
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CRB_REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          bank[gi] <= CRB_RESET_VALUE;
        end else if (data_write && register_index == 5'(gi) && !pen_sel) begin
          bank[gi] <= data_in; // [RULE_19] [RULE_20]
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_out <= CRB_RESET_VALUE;
    end else begin
      data_out <= read_data;
    end
  end

  assign data_oe_b = !data_read; // [RULE_23]

  wire [5:0] lines_raw = {1'b0, bank[CRB_IDX_LINES][CRB_LINES_W-1:0]};
  wire [3:0] vw = bank[CRB_IDX_SYNCW][7:4];
  assign timing.h_period = {1'b0, bank[CRB_IDX_HTOTAL]} + CRB_ONE; // [RULE_03] [RULE_14]
  assign timing.h_displayed = bank[CRB_IDX_HDISP]; // [RULE_17]
  assign timing.h_sync_start = {1'b0, bank[CRB_IDX_HSYNC]} + CRB_ONE; // [RULE_18]
  assign timing.hsync_width_bits = bank[CRB_IDX_SYNCW][3:0]; // [RULE_06]
  assign timing.vsync_lines = (vw == CRB_VSYNC_ZERO_LINES) ? CRB_VSYNC_MAX_LINES
                              : {1'b0, vw}; // [RULE_07]
  assign timing.v_rows = {1'b0, bank[CRB_IDX_VTOTAL]} + CRB_ONE; // [RULE_03]
  assign timing.v_sync_row = {1'b0, bank[CRB_IDX_VSYNC]} + CRB_ONE; // [RULE_03]
  assign timing.raster_mode = crb_raster_e'(bank[CRB_IDX_MODE][1:0]); // [RULE_08]
  assign timing.row_line_count = (timing.raster_mode == CRB_RASTER_ILACE_VIDEO)
                                 ? lines_raw + CRB_TWO
                                 : lines_raw + CRB_ONE[5:0]; // [RULE_04]
  assign timing.visible_skew = bank[CRB_IDX_MODE][CRB_SKEW_LSB+1:CRB_SKEW_LSB]; // [RULE_09]
  assign timing.cursor_skew = bank[CRB_IDX_MODE][CRB_CSKEW_LSB+1:CRB_CSKEW_LSB]; // [RULE_10]
  assign timing.cursor_mode = crb_cursor_e'(bank[CRB_IDX_CURS][CRB_CMODE_LSB+1:CRB_CMODE_LSB]); // [RULE_11]
  assign timing.cursor_screen_select = bank[CRB_IDX_CURS][CRB_TOP_BIT]; // [RULE_12]
  assign timing.dual_screen_select = bank[CRB_IDX_SPLIT][CRB_TOP_BIT]; // [RULE_13]
  assign timing.display_origin = {bank[CRB_IDX_ORG_H], bank[CRB_IDX_ORG_L]}; // [RULE_19]
  assign timing.cursor_location = {bank[CRB_IDX_CUR_H], bank[CRB_IDX_CUR_L]}; // [RULE_20]

  // Assertions
  index_load_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    index_write |=> register_index == $past(data_in[4:0])) // [RULE_02]
    else $error("index not loaded");
  bad_index_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (selected && register_select && !index_valid) |=> data_out == CRB_RESET_VALUE) // [RULE_22]
    else $error("unmapped index read not zero");
  deselect_undriven_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    chip_select_b |-> data_oe_b) // [RULE_23]
    else $error("bus driven while deselected");
  deselect_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    chip_select_b |=> $stable(timing) && $stable(register_index)) // [RULE_23]
    else $error("state changed while deselected");
  htotal_plus_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    timing.h_period == {1'b0, bank[CRB_IDX_HTOTAL]} + CRB_ONE) // [RULE_14]
    else $error("horizontal period wrong");
  vsync_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (vw == CRB_VSYNC_ZERO_LINES) |-> timing.vsync_lines == CRB_VSYNC_MAX_LINES) // [RULE_07]
    else $error("vsync zero code not sixteen");
  origin_write_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (data_write && register_index == CRB_IDX_ORG_L) |=> timing.display_origin[7:0] == $past(data_in)) // [RULE_19]
    else $error("origin low not written");
  pen_readonly_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (data_read && register_index == CRB_IDX_PEN_H) |=> data_out == $past(pen_high)) // [RULE_21]
    else $error("pen high read wrong");
  ilace_lines_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    timing.raster_mode == CRB_RASTER_ILACE_VIDEO |-> timing.row_line_count == lines_raw + CRB_TWO) // [RULE_04]
    else $error("row line count wrong");
endmodule // crb_timing_regs
`default_nettype wire

// ### testbench/crb_host_model.sv
// Host bus model for the register bank access cycle
`timescale 1ns/1ns
`default_nettype none
module crb_host_model (
  input wire logic ref_clk,
  output logic chip_select_b,
  output logic register_select,
  output logic read_not_write,
  output logic bus_strobe,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_b
);
  initial begin
    chip_select_b = 1'b1;
    register_select = 1'b0;
    read_not_write = 1'b0;
    bus_strobe = 1'b0;
    data_in = 8'h00;
  end
  task automatic put(input logic rs, input logic [7:0] d, input logic cs_b);
    @(posedge ref_clk);
    chip_select_b <= cs_b;
    register_select <= rs;
    read_not_write <= 1'b0;
    bus_strobe <= 1'b1;
    data_in <= d;
    @(posedge ref_clk);
    chip_select_b <= 1'b1;
    bus_strobe <= 1'b0;
    data_in <= ~d;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    put(1'b0, i, 1'b0);
    put(1'b1, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d, output logic o);
    put(1'b0, i, 1'b0);
    @(posedge ref_clk);
    chip_select_b <= 1'b0;
    register_select <= 1'b1;
    read_not_write <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    d = data_out;
    o = data_oe_b;
    @(posedge ref_clk);
    chip_select_b <= 1'b1;
    read_not_write <= 1'b0;
  endtask
endmodule // crb_host_model
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the display timing register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import crb_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cs_b, rs, rnw, stb, oe_b, o;
  logic [7:0] din, dout, v;
  logic [15:0] pen = 16'hA5C3;
  logic [15:0] w [11] = '{16'h0907, 16'h003F, 16'h0128, 16'h0231, 16'h041E, 16'h071B,
    16'h1280, 16'h0C12, 16'h0D34, 16'h0E56, 16'h0F78};
  crb_timing_s t;
  int mismatches = 0;
  int num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  crb_host_model host (.ref_clk(ref_clk), .chip_select_b(cs_b), .register_select(rs),
    .read_not_write(rnw), .bus_strobe(stb), .data_in(din), .data_out(dout),
    .data_oe_b(oe_b));
  crb_timing_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .chip_select_b(cs_b),
    .register_select(rs), .read_not_write(rnw), .bus_strobe(stb), .data_in(din),
    .data_out(dout), .data_oe_b(oe_b), .pen_capture(pen), .timing(t));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check(t.h_period, 16'h0001);
    check(t.vsync_lines, 16'h0010);
    foreach (w[i]) host.wr(w[i][15:8], w[i][7:0]);
    @(posedge ref_clk);
    #1;
    check(t.h_period, 16'h0040);
    check(t.h_displayed, 16'h0028);
    check(t.h_sync_start, 16'h0032);
    check(t.v_rows, 16'h001F);
    check(t.v_sync_row, 16'h001C);
    check(t.dual_screen_select, 16'h0001);
    check(t.display_origin, 16'h1234);
    check(t.cursor_location, 16'h5678);
    for (int m = 0; m < 4; m++) begin
      host.wr(8'h03, {4'(m * 5), 4'(m + 1)});
      host.wr(8'h08, {m == 3 ? 4'h0 : {2'(m), 2'(m)}, 2'h0, 2'(m)});
      host.wr(8'h0A, {1'(m), 2'(m), 5'h03});
      @(posedge ref_clk);
      #1;
      check(t.vsync_lines, m == 0 ? 16'h0010 : 16'(m * 5));
      check(t.hsync_width_bits, 16'(m + 1));
      check(t.raster_mode, 16'(m));
      check(t.visible_skew, m == 3 ? 16'h0000 : 16'(m));
      check(t.cursor_skew, m == 3 ? 16'h0000 : 16'(m));
      check(t.cursor_mode, 16'(m));
      check(t.cursor_screen_select, 16'(m % 2));
      check(t.row_line_count, m == 3 ? 16'h0009 : 16'h0008);
    end
    host.rd(8'h0C, v, o);
    check(v, 16'h0012);
    check(o, 16'h0000);
    host.rd(8'h0F, v, o);
    check(v, 16'h0078);
    host.wr(8'h10, 8'h00);
    host.rd(8'h10, v, o);
    check(v, 16'h00A5);
    host.rd(8'h11, v, o);
    check(v, 16'h00C3);
    host.rd(8'h00, v, o);
    check(v, 16'h0000);
    host.wr(8'h18, 8'hFF);
    host.rd(8'h18, v, o);
    check(v, 16'h0000);
    check(t.h_period, 16'h0040);
    host.put(1'b0, 8'h0C, 1'b0);
    host.put(1'b1, 8'hEE, 1'b1);
    @(posedge ref_clk);
    #1;
    check(oe_b, 16'h0001);
    check(t.display_origin, 16'h1234);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
